// ---- design/dmasbr_req_bits.v ----
`timescale 1ns/100ps
`include "dmasbr_regs.vh"

// Set/clear flag bank: set wins over clear in the same cycle only on an idle bit; on a set bit clear wins
module dmasbr_req_bits #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] MASK = {WIDTH{1'b1}}
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] set_in,
    input  wire [WIDTH-1:0] clr_in,
    output reg  [WIDTH-1:0] flags_ff,
    output reg  [WIDTH-1:0] new_ff
);
    wire [WIDTH-1:0] nxt_flags;
    wire [WIDTH-1:0] fresh;

    // Only bits that were idle start a new request
    assign fresh     = set_in & ~flags_ff & MASK;
    assign nxt_flags = ((flags_ff & ~clr_in) | fresh) & MASK;

    // Flags and one-cycle start pulses
    always @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff <= {WIDTH{1'b0}};
            new_ff   <= {WIDTH{1'b0}};
        end else begin
            flags_ff <= nxt_flags;
            new_ff   <= fresh;
        end
    end
endmodule // dmasbr_req_bits

// ---- design/dmasbr_top.v ----
`timescale 1ns/100ps
`include "dmasbr_regs.vh"

module dmasbr_top #(
    parameter NUM_CHAN = 2,
    parameter NUM_REQ  = 16
) (
    input  wire                aclk,
    input  wire                aresetn,
    // AXI4-Lite slave
    input  wire [3:0]          s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output reg                 s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output reg                 s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [3:0]          s_axi_araddr,
    input  wire                s_axi_arvalid,
    output reg                 s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    // Transfer engine side
    input  wire [NUM_CHAN-1:0] chan_done,
    input  wire [NUM_REQ-1:0]  burst_done,
    output reg  [NUM_CHAN-1:0] chan_active_ff,
    output reg  [NUM_REQ-1:0]  burst_req_pulse_ff,
    output reg  [NUM_REQ-1:0]  sw_burst_req_ff
);
    // Bus-side holding state and flags
    reg                 cfg_operate_ff;
    reg                 aw_held_ff;
    reg                 w_held_ff;
    reg  [3:0]          awaddr_ff;
    reg  [31:0]         wdata_ff;
    reg  [3:0]          wstrb_ff;
    reg  [NUM_CHAN-1:0] chan_flags_ff;
    // Combinational next values
    reg  [NUM_CHAN-1:0] chan_set;
    reg  [NUM_REQ-1:0]  req_set;
    reg  [1:0]          nxt_bresp;
    reg                 nxt_operate;
    reg  [31:0]         nxt_rdata;
    reg  [1:0]          nxt_rresp;
    reg                 rd_ok;
    wire                nxt_awready;
    wire                nxt_wready;
    wire                nxt_arready;
    wire [NUM_CHAN-1:0] nxt_chan_flags;
    wire                do_write;
    wire                do_read;
    // Request flag bank outputs
    wire [NUM_REQ-1:0]  req_flags;
    wire [NUM_REQ-1:0]  req_new;

    // Register word for an offset; stopped circuit hides the DMA words
    function [32:0] read_word;
        input [3:0] addr;
        input       operate;
        begin
            case (addr)
                `DMASBR_OFS_CONFIG:
                    read_word = {1'b1, 31'h00000000, operate};
                `DMASBR_OFS_CHAN_ACTIVE:
                    read_word = operate ? {1'b1, {(32-NUM_CHAN){1'b0}}, chan_flags_ff}
                                        : 33'h000000000;
                `DMASBR_OFS_SW_BURST_REQ:
                    read_word = operate ? {1'b1, {(32-NUM_REQ){1'b0}}, req_flags}
                                        : 33'h000000000;
                default:
                    read_word = 33'h000000000;
            endcase
        end
    endfunction

    dmasbr_req_bits #(
        .WIDTH (NUM_REQ),
        .MASK  (`DMASBR_REQ_MASK)
    ) u_req_bits (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .set_in   (req_set),
        .clr_in   (burst_done),
        .flags_ff (req_flags),
        .new_ff   (req_new)
    );

    // A write completes once both halves are held and no response waits
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign do_read  = s_axi_arvalid && s_axi_arready;

    // Ready stands one cycle; a held half is refused until B is taken
    assign nxt_awready = !aw_held_ff && !s_axi_awready && s_axi_awvalid;
    assign nxt_wready  = !w_held_ff && !s_axi_wready && s_axi_wvalid;
    assign nxt_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

    // Start sets, finish clears, start wins a tie
    assign nxt_chan_flags = (chan_flags_ff & ~chan_done) | chan_set;

    // Decode of the write that completes this cycle
    always @* begin
        req_set     = {NUM_REQ{1'b0}};
        chan_set    = {NUM_CHAN{1'b0}};
        nxt_operate = cfg_operate_ff;
        nxt_bresp   = `DMASBR_RESP_OKAY;
        if (do_write) begin
            case (awaddr_ff)
                `DMASBR_OFS_CONFIG: begin
                    if (wstrb_ff[0])
                        nxt_operate = wdata_ff[`DMASBR_CFG_OPERATE_BIT];
                end
                `DMASBR_OFS_SW_BURST_REQ: begin
                    // Zeros ignored; ones only on enabled lanes
                    if (cfg_operate_ff) begin
                        req_set = wdata_ff[NUM_REQ-1:0] &
                                  {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
                    end else begin
                        nxt_bresp = `DMASBR_RESP_SLVERR;
                    end
                end
                `DMASBR_OFS_CHAN_START: begin
                    if (cfg_operate_ff && wstrb_ff[0])
                        chan_set = wdata_ff[NUM_CHAN-1:0];
                    else if (!cfg_operate_ff)
                        nxt_bresp = `DMASBR_RESP_SLVERR;
                end
                `DMASBR_OFS_CHAN_ACTIVE: begin
                    if (!cfg_operate_ff)
                        nxt_bresp = `DMASBR_RESP_SLVERR;
                end
                default: nxt_bresp = `DMASBR_RESP_SLVERR;
            endcase
        end
    end

    // Read data and response; top bit of the word marks a mapped, open register
    always @* begin
        {rd_ok, nxt_rdata} = read_word(s_axi_araddr, cfg_operate_ff);
        nxt_rresp          = rd_ok ? `DMASBR_RESP_OKAY : `DMASBR_RESP_SLVERR;
    end

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DMASBR_RESP_OKAY;
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            awaddr_ff     <= 4'h0;
            wdata_ff      <= 32'h00000000;
            wstrb_ff      <= 4'h0;
        end else begin
            s_axi_awready <= nxt_awready;
            s_axi_wready  <= nxt_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= nxt_bresp;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
            end
        end
    end

    // Read channel: one cycle arready, data the next
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DMASBR_RESP_OKAY;
        end else begin
            s_axi_arready <= nxt_arready;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= nxt_rdata;
                s_axi_rresp  <= nxt_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Channel flags: start sets, finish clears, start wins a tie
    always @(posedge aclk) begin
        if (!aresetn) begin
            chan_flags_ff  <= `DMASBR_RST_CHAN;
            chan_active_ff <= `DMASBR_RST_CHAN;
            cfg_operate_ff <= 1'b0;
        end else begin
            chan_flags_ff  <= nxt_chan_flags;
            chan_active_ff <= nxt_chan_flags;
            cfg_operate_ff <= nxt_operate;
        end
    end

    // Engine-facing copies, registered so outputs come from flip-flops
    always @(posedge aclk) begin
        if (!aresetn) begin
            burst_req_pulse_ff <= `DMASBR_RST_REQ;
            sw_burst_req_ff    <= `DMASBR_RST_REQ;
        end else begin
            burst_req_pulse_ff <= req_new;
            sw_burst_req_ff    <= req_flags;
        end
    end
endmodule // dmasbr_top

// ---- include/dmasbr_regs.vh ----
// Functional notes
// - One read-only active flag per channel 0 and 1, high while enabled.
// - A channel's active flag clears itself when its transfer finishes.
// - Burst request bits sit at positions 0 to 13 and 15; 14 reserved.
// - Reading a request bit shows 1 while its burst runs, 0 when stopped.
// - Writing 1 to a request bit raises a burst request on that line.
// - Writing 0 to a request bit does nothing.
// - A request bit clears when its software burst completes.
// - While the circuit is stopped, reads and writes of every register except the configuration word are blocked.
`ifndef DMASBR_REGS_VH
`define DMASBR_REGS_VH

// Byte offsets of the register words
`define DMASBR_OFS_CHAN_ACTIVE  4'h0
`define DMASBR_OFS_SW_BURST_REQ 4'h4
`define DMASBR_OFS_CONFIG       4'h8
`define DMASBR_OFS_CHAN_START   4'hC

// Implemented request lines: 0..13 and 15
`define DMASBR_REQ_MASK         16'hBFFF
// Circuit operate bit in the configuration word
`define DMASBR_CFG_OPERATE_BIT  0
// Responses
`define DMASBR_RESP_OKAY        2'h0
`define DMASBR_RESP_SLVERR      2'h2
// Reset values
`define DMASBR_RST_REQ          16'h0000
`define DMASBR_RST_CHAN         2'h0

`endif

// ---- tb/dmasbr_assertions.sv ----
`timescale 1ns/100ps
`include "dmasbr_regs.vh"

module dmasbr_assertions #(
    parameter NUM_CHAN = 2,
    parameter NUM_REQ  = 16
) (
    input wire                aclk,
    input wire                aresetn,
    input wire [1:0]          s_axi_bresp,
    input wire                s_axi_bvalid,
    input wire                s_axi_bready,
    input wire [31:0]         s_axi_rdata,
    input wire [1:0]          s_axi_rresp,
    input wire                s_axi_rvalid,
    input wire                s_axi_rready,
    input wire [NUM_CHAN-1:0] chan_done,
    input wire [NUM_REQ-1:0]  burst_done,
    input wire [NUM_CHAN-1:0] chan_active_ff,
    input wire [NUM_REQ-1:0]  burst_req_pulse_ff,
    input wire [NUM_REQ-1:0]  sw_burst_req_ff
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Responses left waiting by the master
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_resv_bit_zero: assert property (!sw_burst_req_ff[14])
        else $error("reserved request bit set");
    a_pulse_single: assert property ((burst_req_pulse_ff & $past(burst_req_pulse_ff)) == 0)
        else $error("request pulse longer than one cycle");
    a_pulse_when_idle: assert property ((burst_req_pulse_ff & $past(sw_burst_req_ff)) == 0)
        else $error("second request on a running line");
    a_pulse_sets_bit: assert property ((burst_req_pulse_ff & ~sw_burst_req_ff) == 0)
        else $error("request pulse without its request bit");
    a_done_clears_req: assert property (burst_done[0] |-> ##[1:3] !sw_burst_req_ff[0])
        else $error("request bit kept after burst done");
    a_done_clears_chan: assert property (chan_done[0] |-> ##[1:3] !chan_active_ff[0])
        else $error("active flag kept after channel done");
    a_bresp_held: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rdata_held: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == `DMASBR_RESP_SLVERR
        |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
endmodule // dmasbr_assertions

bind dmasbr_top dmasbr_assertions #(
    .NUM_CHAN (NUM_CHAN),
    .NUM_REQ  (NUM_REQ)
) u_chk (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .s_axi_bresp        (s_axi_bresp),
    .s_axi_bvalid       (s_axi_bvalid),
    .s_axi_bready       (s_axi_bready),
    .s_axi_rdata        (s_axi_rdata),
    .s_axi_rresp        (s_axi_rresp),
    .s_axi_rvalid       (s_axi_rvalid),
    .s_axi_rready       (s_axi_rready),
    .chan_done          (chan_done),
    .burst_done         (burst_done),
    .chan_active_ff     (chan_active_ff),
    .burst_req_pulse_ff (burst_req_pulse_ff),
    .sw_burst_req_ff    (sw_burst_req_ff)
);

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`include "dmasbr_regs.vh"

module tb_top;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, chan_done = 0, chan_active_ff;
    logic [15:0] burst_done = 0, burst_req_pulse_ff, sw_burst_req_ff;
    int          err_count = 0, checked = 0, cyc = 0, pulses = 0;
    localparam   rok = `DMASBR_RESP_OKAY, rerr = `DMASBR_RESP_SLVERR;
    localparam   a_act = `DMASBR_OFS_CHAN_ACTIVE, a_req = `DMASBR_OFS_SW_BURST_REQ;

    dmasbr_top DUT (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .s_axi_awaddr       (s_axi_awaddr),
        .s_axi_awvalid      (s_axi_awvalid),
        .s_axi_awready      (s_axi_awready),
        .s_axi_wdata        (s_axi_wdata),
        .s_axi_wstrb        (s_axi_wstrb),
        .s_axi_wvalid       (s_axi_wvalid),
        .s_axi_wready       (s_axi_wready),
        .s_axi_bresp        (s_axi_bresp),
        .s_axi_bvalid       (s_axi_bvalid),
        .s_axi_bready       (s_axi_bready),
        .s_axi_araddr       (s_axi_araddr),
        .s_axi_arvalid      (s_axi_arvalid),
        .s_axi_arready      (s_axi_arready),
        .s_axi_rdata        (s_axi_rdata),
        .s_axi_rresp        (s_axi_rresp),
        .s_axi_rvalid       (s_axi_rvalid),
        .s_axi_rready       (s_axi_rready),
        .chan_done          (chan_done),
        .burst_done         (burst_done),
        .chan_active_ff     (chan_active_ff),
        .burst_req_pulse_ff (burst_req_pulse_ff),
        .sw_burst_req_ff    (sw_burst_req_ff)
    );

    always #5 aclk = ~aclk;
    // Tally raised requests; guard against a hung handshake
    always @(posedge aclk) begin
        if (aresetn) pulses <= pulses + $countones(burst_req_pulse_ff);
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            final_report;
        end
    end
    task automatic chk(input [31:0] s, input [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input [3:0] a, input [31:0] d, input [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        // Response left waiting a cycle so it must stand until taken
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
    endtask
    task automatic rd(input [3:0] a, input [31:0] d, input [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        // Data left waiting a cycle so it must stand until taken
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
    endtask
    task automatic final_report;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // Circuit stopped after reset: request word locked
        rd(a_req, 32'h0, rerr);
        wr(a_req, 32'h1, rerr);
        wr(`DMASBR_OFS_CONFIG, 32'h1, rok);
        rd(a_req, 32'h0, rok);
        rd(a_act, 32'h0, rok);
        // Every line at once; reserved bit never sets
        wr(a_req, 32'hFFFFFFFF, rok);
        rd(a_req, 32'h0000BFFF, rok);
        chk(sw_burst_req_ff, 32'h0000BFFF);
        chk(pulses, 32'hF);
        // Repeated ones and zeros must not disturb running bursts
        wr(a_req, 32'hFFFFFFFF, rok);
        wr(a_req, 32'h0, rok);
        rd(a_req, 32'h0000BFFF, rok);
        chk(pulses, 32'hF);
        // Lines 0 and 15 finish, then line 0 is raised again
        burst_done <= 16'h8001;
        @(posedge aclk);
        burst_done <= 16'h0;
        rd(a_req, 32'h00003FFE, rok);
        wr(a_req, 32'h1, rok);
        rd(a_req, 32'h00003FFF, rok);
        chk(pulses, 32'h10);
        // Byte lanes: line 15 only raises when its lane is enabled
        s_axi_wstrb <= 4'h1;
        wr(a_req, 32'h00008000, rok);
        rd(a_req, 32'h00003FFF, rok);
        s_axi_wstrb <= 4'h2;
        wr(a_req, 32'h00008000, rok);
        s_axi_wstrb <= 4'hF;
        rd(a_req, 32'h0000BFFF, rok);
        chk(pulses, 32'h11);
        // Channel flags: start both, finish channel 0, try a write
        wr(`DMASBR_OFS_CHAN_START, 32'h3, rok);
        rd(a_act, 32'h3, rok);
        chan_done <= 2'h1;
        @(posedge aclk);
        chan_done <= 2'h0;
        wr(a_act, 32'h0, rok);
        rd(a_act, 32'h2, rok);
        chk(chan_active_ff, 32'h2);
        // Stopped again: live flags are hidden from reads
        wr(`DMASBR_OFS_CONFIG, 32'h0, rok);
        rd(a_act, 32'h0, rerr);
        rd(a_req, 32'h0, rerr);
        final_report;
    end
endmodule // tb_top
